// ### src/spi_xfer_regs.vh
// Register indices, field positions and reset values for the SPI block.
// Byte address of a register is four times its index.
`ifndef SPI_XFER_REGS_VH
`define SPI_XFER_REGS_VH

// Register indices
`define IDX_SCR      2'h0
`define IDX_DSCR     2'h1
`define IDX_RXD      2'h2
`define IDX_TXD      2'h3

// status_control_reg fields
`define SCR_SPR_HI   15
`define SCR_SPR_LO   13
`define SCR_DSO      12
`define SCR_ERROR_IRQ_ENABLE    11
`define SCR_MODE_FAULT_ENABLE   10
`define SCR_SPRIE    9
`define SCR_MSTR     8
`define SCR_CPOL     7
`define SCR_CLOCK_PHASE     6
`define SCR_SPE      5
`define SCR_SPTIE    4
`define SCR_RXF      3
`define SCR_OVF      2
`define SCR_MODE_FAULT_FLAG     1
`define SCR_TXE      0

// Control half (bits 15..4) of the status_control_reg reset value 16'h6140
`define SCR_CTL_RST  12'h614

// Data size register fields
`define DSCR_WOM     15
`define DSCR_DS_HI   3
`define DSCR_DS_LO   0
`define DS_RST       4'hf

`endif

// ### src/spi_xfer.v
// SPI master/slave transfer engine with overflow and mode-fault logic.
// Assumes an Avalon-MM master on clk; pins come from outside clk's domain.
//
// How it works
// - Master transfer starts after a data write
// - Phase picks first half inactive or edge
// - Divider runs only when enabled master
// - Queued word follows previous transfer at once
// - Data write clears, buffer move sets empty
// - Done word fills rx register, sets full
// - No new word resends last shift value
// - Idle slave reloads fast, busy slave waits
// - Overflow checked at next-to-last capture strobe, last if one bit
// - Overflow blocks new words, old stays readable
// - Status read then data read clears overflow
// - One enable gates combined error request
// - Master drives clock and mosi, slave miso
// - Mode fault from select against the mode
// - Fault enable gates setting, not holding
// - Master fault disables, empties, resets counter
// - Slave transfer start and end by phase
// - Phase zero select toggle alone faults
// - Slave fault only flags and requests
// - Deselected slave floats miso, ignores clock
// - Write one clears fault when no condition
`timescale 1ns/1ps
`include "spi_xfer_regs.vh"

module spi_xfer
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output wire [31:0] readdata,
  output wire        waitrequest,
  input  wire        sclk_in,
  output wire        sclk_out,
  output wire        sclk_oe,
  input  wire        mosi_in,
  output wire        mosi_out,
  output wire        mosi_oe,
  input  wire        miso_in,
  output wire        miso_out,
  output wire        miso_oe,
  input  wire        ss_n_in,
  output wire        err_irq,
  output wire        rx_irq,
  output wire        tx_irq
);

  reg  [3:0]  sync1_r;
  reg  [3:0]  sync2_r;
  reg  [3:0]  prev_r;
  reg  [15:4] ctl_r;
  reg         wom_r;
  reg  [3:0]  ds_r;
  reg         rxf_r;
  reg         ovf_r;
  reg         mode_fault_flag_r;
  reg         txe_r;
  reg         arm_r;
  reg  [15:0] buf_r;
  reg         buf_full_r;
  reg  [15:0] txw_r;
  reg  [15:0] rxsh_r;
  reg  [15:0] rxd_r;
  reg         busy_r;
  reg  [5:0]  h_r;
  reg  [6:0]  div_r;
  reg         ph_r;
  reg         sclk_r;
  reg         ack_r;
  reg  [15:0] rdata_r;
  reg         busy_nxt;
  reg  [5:0]  h_nxt;
  reg  [15:0] scr_val;

  // Synchronised pins: 3 sclk, 2 mosi, 1 miso, 0 ss_n
  wire sclk_s = sync2_r[3];
  wire mosi_s = sync2_r[2];
  wire miso_s = sync2_r[1];
  wire ss_s   = sync2_r[0];
  wire sclk_d = prev_r[3];
  wire ss_d   = prev_r[0];

  wire [2:0] spr    = ctl_r[`SCR_SPR_HI:`SCR_SPR_LO];
  wire       dso    = ctl_r[`SCR_DSO];
  wire       error_irq_enable  = ctl_r[`SCR_ERROR_IRQ_ENABLE];
  wire       mode_fault_enable = ctl_r[`SCR_MODE_FAULT_ENABLE];
  wire       sprie  = ctl_r[`SCR_SPRIE];
  wire       mstr   = ctl_r[`SCR_MSTR];
  wire       cpol   = ctl_r[`SCR_CPOL];
  wire       clock_phase   = ctl_r[`SCR_CLOCK_PHASE];
  wire       module_enable    = ctl_r[`SCR_SPE];
  wire       sptie  = ctl_r[`SCR_SPTIE];

  // Bus decode
  wire [1:0] idx    = address[3:2];
  wire       req    = read | write;
  wire       rd_go  = read & ack_r;
  wire       wr_go  = write & ack_r;
  wire       wr_scr = wr_go & (idx == `IDX_SCR);
  wire       wr_txd = wr_go & (idx == `IDX_TXD);
  wire       rd_scr = rd_go & (idx == `IDX_SCR);
  wire       rd_rxd = rd_go & (idx == `IDX_RXD);

  // Master bit clock: half period is 2^spr bus cycles
  wire       m_run  = module_enable & mstr;
  wire [7:0] halfm1 = (8'h01 << spr) - 8'h01;
  wire       htick  = m_run & (div_r == halfm1[6:0]);

  // Transfer geometry
  wire [5:0] last_h = {1'b0, ds_r, 1'b1};
  wire [5:0] end_h  = {1'b0, ds_r, 1'b0} + 6'h02;
  wire [5:0] ovf_h  = (ds_r == 4'h0) ? last_h : last_h - 6'h02;

  // Slave events; a high select hides every clock edge
  wire s_on    = module_enable & ~mstr;
  wire s_edge  = s_on & ~ss_s & (sclk_s ^ sclk_d);
  wire s_start = ~busy_r & (clock_phase ? (s_edge & (sclk_s != cpol))
                                 : (s_on & ss_d & ~ss_s));

  wire step    = busy_r & (mstr ? htick : s_edge);
  wire [5:0] h_inc = h_r + 6'h01;
  wire sample  = step & h_inc[0];
  wire fin     = step & (h_inc == ((~mstr & clock_phase) ? last_h : end_h));
  wire m_start = htick & ph_r & buf_full_r & (~busy_r | fin);
  wire s_load  = s_on & ~busy_r & ~s_start & buf_full_r;

  // Mode faults
  wire m_cond  = mstr & ~ss_s;
  wire m_flt   = mode_fault_enable & module_enable & m_cond;
  wire s_flt   = mode_fault_enable & s_on & busy_r & ss_s & ~ss_d;

  // Receive bit placement and completed word
  wire [3:0]  bi_n   = h_inc[4:1];
  wire [3:0]  pos    = dso ? bi_n : ds_r - bi_n;
  wire        din    = mstr ? miso_s : mosi_s;
  wire [15:0] rx_wrd = rxsh_r | ({15'h0000, din} << pos);
  wire        ovf_set = sample & (h_inc == ovf_h) & rxf_r;
  wire        rx_done = sample & (h_inc == last_h);

  // Outgoing bit comes from the held word, so it resends when idle
  wire [3:0] bi   = h_r[4:1];
  wire       obit = dso ? txw_r[bi] : txw_r[ds_r - bi];

  assign waitrequest = req & ~ack_r;
  assign readdata    = {16'h0000, rdata_r};
  assign sclk_oe     = m_run;
  assign mosi_oe     = m_run;
  assign miso_oe     = s_on & ~ss_s;
  assign sclk_out    = sclk_r;
  assign mosi_out    = obit;
  assign miso_out    = obit;
  assign err_irq     = error_irq_enable & (ovf_r | mode_fault_flag_r);
  assign rx_irq      = sprie & rxf_r;
  assign tx_irq      = sptie & module_enable & txe_r;

  always @*
  begin
    scr_val = {ctl_r, rxf_r, ovf_r, mode_fault_flag_r, txe_r};
    busy_nxt = busy_r;
    h_nxt = h_r;
    if (m_start | s_start)
    begin
      busy_nxt = 1'b1;
      h_nxt = 6'h00;
    end
    else if (fin)
    begin
      busy_nxt = 1'b0;
      h_nxt = 6'h00;
    end
    else if (step)
      h_nxt = h_inc;
    if (~module_enable | m_flt | (s_on & ss_s))
    begin
      busy_nxt = 1'b0;
      h_nxt = 6'h00;
    end
  end

  // Two-stage synchronisers, then one stage for edge detection
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
      prev_r  <= 4'hf;
    end
    else
    begin
      sync1_r <= {sclk_in, mosi_in, miso_in, ss_n_in};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Avalon slave: one wait cycle, read data registered
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (read & ~ack_r)
      begin
        case (idx)
          `IDX_SCR:  rdata_r <= scr_val;
          `IDX_DSCR: rdata_r <= {wom_r, 11'h000, ds_r};
          `IDX_RXD:  rdata_r <= rxd_r;
          default:   rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // Master divider, free running while enabled as master
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r <= 7'h00;
      ph_r  <= 1'b0;
    end
    else if (!m_run)
    begin
      div_r <= 7'h00;
      ph_r  <= 1'b0;
    end
    else if (htick)
    begin
      div_r <= 7'h00;
      ph_r  <= ~ph_r;
    end
    else
      div_r <= div_r + 7'h01;
  end

  // Transfer state and clock line
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      h_r    <= 6'h00;
      sclk_r <= 1'b0;
    end
    else
    begin
      busy_r <= busy_nxt;
      h_r    <= h_nxt;
      sclk_r <= cpol ^ (mstr & busy_nxt & (clock_phase ? ~h_nxt[0] : h_nxt[0]));
    end
  end

  // Configuration and transmit path
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r      <= `SCR_CTL_RST;
      wom_r      <= 1'b0;
      ds_r       <= `DS_RST;
      buf_r      <= 16'h0000;
      buf_full_r <= 1'b0;
      txw_r      <= 16'h0000;
      txe_r      <= 1'b0;
    end
    else
    begin
      if (wr_scr)
        ctl_r <= writedata[15:4];
      if (wr_go & (idx == `IDX_DSCR))
      begin
        wom_r <= writedata[`DSCR_WOM];
        ds_r  <= writedata[`DSCR_DS_HI:`DSCR_DS_LO];
      end
      if (m_start | s_load | (s_start & buf_full_r))
      begin
        txw_r      <= buf_r;
        buf_full_r <= 1'b0;
        txe_r      <= 1'b1;
      end
      else if (~buf_full_r & ~txe_r)
        txe_r <= 1'b1;
      if (m_flt)
      begin
        ctl_r[`SCR_SPE] <= 1'b0;
        buf_full_r      <= 1'b0;
        txe_r           <= 1'b1;
      end
      else if (wr_txd)
      begin
        buf_r      <= writedata[15:0];
        buf_full_r <= 1'b1;
        txe_r      <= 1'b0;
      end
    end
  end

  // Receive path and error flags
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxsh_r <= 16'h0000;
      rxd_r  <= 16'h0000;
      rxf_r  <= 1'b0;
      ovf_r  <= 1'b0;
      arm_r  <= 1'b0;
      mode_fault_flag_r <= 1'b0;
    end
    else
    begin
      if (m_start | s_start)
        rxsh_r <= 16'h0000;
      else if (sample)
        rxsh_r <= rx_wrd;
      if (rd_rxd)
        rxf_r <= 1'b0;
      if (rx_done & ~ovf_r & ~ovf_set)
      begin
        rxd_r <= rx_wrd;
        rxf_r <= 1'b1;
      end
      if (rd_scr & ovf_r)
        arm_r <= 1'b1;
      else if (rd_rxd)
        arm_r <= 1'b0;
      if (ovf_set)
        ovf_r <= 1'b1;
      else if (rd_rxd & arm_r)
        ovf_r <= 1'b0;
      if (m_flt | s_flt)
        mode_fault_flag_r <= 1'b1;
      else if (wr_scr & writedata[`SCR_MODE_FAULT_FLAG] & ~m_cond)
        mode_fault_flag_r <= 1'b0;
    end
  end

endmodule // spi_xfer

// ### verif/spi_xfer_checker.sv
// Port checker for spi_xfer.
// Assumes bind to spi_xfer; control bits shadowed from bus writes.
`timescale 1ns/1ps
module spi_xfer_checker
(
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire        waitrequest,
  input wire        sclk_out,
  input wire        sclk_oe,
  input wire        mosi_oe,
  input wire        miso_oe,
  input wire        ss_n_in,
  input wire        err_irq
);
  reg [15:0] ctl_r;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      ctl_r <= 16'h6140;
    else if (write && !waitrequest && address[3:2] == 2'h0)
      ctl_r <= writedata[15:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wait_first;
    $rose(read || write) |-> waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("first cycle not stalled");
  property p_wait_one;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("answer late");
  property p_start;
    write && !waitrequest && address[3:2] == 2'h3 && sclk_oe && ctl_r[15:13] == 3'h3 && !ctl_r[7]
      |-> ##[1:40] sclk_out;
  endproperty
  a_start: assert property (p_start)
    else $error("transfer start late");
  property p_idle_sclk;
    (!sclk_oe && $stable(ctl_r[7])) [*3] |-> sclk_out == ctl_r[7];
  endproperty
  a_idle_sclk: assert property (p_idle_sclk)
    else $error("clock moves while off");
  property p_dir;
    sclk_oe |-> mosi_oe && !miso_oe;
  endproperty
  a_dir: assert property (p_dir)
    else $error("pin direction clash");
  property p_miso_float;
    ss_n_in [*3] |-> !miso_oe;
  endproperty
  a_miso_float: assert property (p_miso_float)
    else $error("miso driven unselected");
  property p_err_gate;
    err_irq |-> ctl_r[11];
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("error request ungated");
  property p_fault_stop;
    $fell(ss_n_in) && sclk_oe && ctl_r[10] |-> ##[1:5] (!sclk_oe && err_irq == ctl_r[11]);
  endproperty
  a_fault_stop: assert property (p_fault_stop)
    else $error("master fault not taken");
endmodule // spi_xfer_checker

bind spi_xfer spi_xfer_checker i_chk
(
  .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .waitrequest(waitrequest), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
  .err_irq(err_irq)
);

// ### verif/spi_far_slave.sv
// Far-side SPI slave model for master transfers.
// Assumes CPOL 0, CLOCK_PHASE 1, MSB first, 16-bit words.
`timescale 1ns/1ps
module spi_far_slave
(
  input  wire        sclk,
  input  wire        mosi,
  output reg         miso,
  output reg  [15:0] rx_word
);
  reg [15:0] tx_w;
  reg [15:0] sh;
  integer    cnt;
  initial
  begin
    miso = 1'b0;
    rx_word = 16'h0000;
    tx_w = 16'h3c5a;
    cnt = 0;
  end
  always @(posedge sclk)
    miso <= tx_w[15 - cnt];
  always @(negedge sclk)
  begin
    sh = {sh[14:0], mosi};
    cnt = cnt + 1;
    if (cnt == 16)
    begin
      // Next reply is the inverse of the word just received; line flips between frames
      rx_word <= sh;
      tx_w <= ~sh;
      miso <= ~miso;
      cnt = 0;
    end
  end
endmodule // spi_far_slave

// ### verif/spi_xfer_test.sv
// Self-checking bench for spi_xfer.
// Assumes far slave model and bound checker.
`timescale 1ns/1ps
module spi_xfer_test;
  reg         clk;
  reg         rst_n;
  reg  [3:0]  address;
  reg         read;
  reg         write;
  reg  [31:0] writedata;
  reg         ss_n_in;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        sclk_out;
  wire        mosi_out;
  wire        miso_in;
  wire        miso_oe;
  wire        err_irq;
  wire [15:0] far_rx;
  reg  [15:0] got;
  integer     fail_count;
  integer     samples_checked;
  integer     i;
  always #10 clk = ~clk;
  spi_xfer i_dut
  (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sclk_in(1'b0), .sclk_out(sclk_out), .sclk_oe(), .mosi_in(1'b0),
    .mosi_out(mosi_out), .mosi_oe(), .miso_in(miso_in), .miso_out(),
    .miso_oe(miso_oe), .ss_n_in(ss_n_in), .err_irq(err_irq), .rx_irq(), .tx_irq()
  );
  spi_far_slave i_far
  (
    .sclk(sclk_out), .mosi(mosi_out), .miso(miso_in), .rx_word(far_rx)
  );
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [15:0] g, input [15:0] e);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task hang;
  begin
    fail_count = fail_count + 1;
    report_and_stop;
  end
  endtask
  task bus(input rd, input [1:0] idx, input [15:0] d);
    integer n;
  begin
    n = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= rd;
    write <= !rd;
    writedata <= {16'h0000, d};
    // Look at waitrequest away from the edge, then take the edge
    @(negedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      n = n + 1;
      @(negedge clk);
    end
    if (n == 20)
      hang;
    @(posedge clk);
    got = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  end
  endtask
  task poll(input integer b);
    integer k;
  begin
    k = 0;
    got = 16'h0000;
    while (got[b] !== 1'b1 && k < 200)
    begin
      bus(1'b1, 2'h0, 16'h0000);
      k = k + 1;
    end
    if (k == 200)
      hang;
  end
  endtask
  task t_xfer;
  begin
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6141);
    bus(1'b0, 2'h0, 16'h6160);
    bus(1'b0, 2'h3, 16'h1234);
    poll(0);
    bus(1'b0, 2'h3, 16'h5678);
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6160);
    poll(3);
    bus(1'b1, 2'h2, 16'h0000);
    chk(got, 16'h3c5a);
    chk(far_rx, 16'h1234);
    poll(3);
    bus(1'b1, 2'h2, 16'h0000);
    chk(got, 16'hedcb);
    chk(far_rx, 16'h5678);
  end
  endtask
  task t_ovf;
  begin
    bus(1'b0, 2'h3, 16'h0f0f);
    poll(3);
    bus(1'b0, 2'h3, 16'h00ff);
    poll(2);
    i = 0;
    while (far_rx !== 16'h00ff && i < 600)
    begin
      i = i + 1;
      @(posedge clk);
    end
    if (i == 600)
      hang;
    bus(1'b1, 2'h2, 16'h0000);
    chk(got, 16'ha987);
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6161);
  end
  endtask
  task t_fault;
  begin
    bus(1'b0, 2'h0, 16'h6d60);
    ss_n_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk({15'h0000, err_irq}, 16'h0001);
    bus(1'b0, 2'h0, 16'h6d42);
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6d43);
    ss_n_in <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, 2'h0, 16'h6942);
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6941);
    bus(1'b0, 2'h0, 16'h6960);
    ss_n_in <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6961);
    ss_n_in <= 1'b1;
  end
  endtask
  task t_slave;
  begin
    bus(1'b0, 2'h0, 16'h6c20);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge clk);
    chk({15'h0000, miso_oe}, 16'h0001);
    ss_n_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk({15'h0000, miso_oe}, 16'h0000);
    bus(1'b1, 2'h0, 16'h0000);
    chk(got, 16'h6c23);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    ss_n_in = 1'b1;
    got = 16'h0000;
    fail_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_xfer;
    t_ovf;
    t_fault;
    t_slave;
    report_and_stop;
  end
endmodule // spi_xfer_test
